// ---- verilog/polar_weight_pkg.sv ----
package polar_weight_pkg;

  // Register byte offsets on the AXI4-Lite port.
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_XDR_DB   = 8'h04;
  localparam logic [7:0] OFS_GDR_DB   = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_XDR_LIN  = 8'h18;
  localparam logic [7:0] OFS_QUOT_LIN = 8'h1C;

  // Control register fields.
  localparam int CTRL_MODE_LO = 0;
  localparam int CTRL_H_XMT   = 4;
  localparam int CTRL_V_XMT   = 5;
  localparam int CTRL_USE_COPOLAR_RECEIVE_ANSWER  = 6;
  localparam int CTRL_USE_CROSSPOLAR_RECEIVE_ANSWER  = 7;

  // Polarization cases held in the mode field.
  localparam logic [2:0] MODE_FIXED_H  = 3'h0;
  localparam logic [2:0] MODE_FIXED_V  = 3'h1;
  localparam logic [2:0] MODE_SIMUL    = 3'h2;
  localparam logic [2:0] MODE_ALT_SNGL = 3'h3;
  localparam logic [2:0] MODE_ALT_DUAL = 3'h4;

  // Decibel fields are sign and magnitude, magnitude in 1/16 dB steps.
  localparam int         MAG_W       = 9;
  localparam int         DB_SIGN_BIT = 9;
  localparam logic [5:0] MAG_LAST    = 6'h08;
  localparam logic [5:0] DIV_LAST    = 6'h20;

  // Gain of each magnitude bit, unsigned Q16.16, from 1/16 dB up to 16 dB.
  localparam logic [MAG_W-1:0][31:0] DB_STEP_GAIN = {
    32'h0027CF8A, 32'h00064F41, 32'h0002830B, 32'h000195BD, 32'h00014249,
    32'h00011F3D, 32'h00010F2B, 32'h0001077A, 32'h000103B6};

  localparam logic [31:0] Q_ONE  = 32'h00010000;
  localparam logic [31:0] Q_ZERO = 32'h00000000;

  // Input lanes of the correlator stream.
  localparam logic [1:0] LANE_HH = 2'h0;
  localparam logic [1:0] LANE_VH = 2'h1;
  localparam logic [1:0] LANE_VV = 2'h2;
  localparam logic [1:0] LANE_HV = 2'h3;

  // Interrupt status bits.
  localparam int IRQ_W        = 3;
  localparam int IRQ_LOADED   = 0;
  localparam int IRQ_BAD_CFG  = 1;
  localparam int IRQ_NOT_RDY  = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : polar_weight_pkg

// ---- verilog/pol_weight_unit.sv ----
`timescale 1ns/10ps
`default_nettype none
module pol_weight_unit (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [31:0] i_a,
  input  wire logic [31:0] i_b,
  input  wire logic [31:0] i_wa,
  input  wire logic [31:0] i_wb,
  input  wire logic        i_avg,
  output logic      [31:0] o_y
);

  logic signed [64:0] prod_a;
  logic signed [64:0] prod_b;
  logic signed [65:0] sum;
  logic signed [65:0] shifted;
  logic        [31:0] y_nxt;
  logic        [31:0] y_r;

  // Weighted sum of two terms in Q16.16, halved when averaging.
  always_comb begin
    prod_a  = $signed(i_a) * $signed({1'b0, i_wa});
    prod_b  = $signed(i_b) * $signed({1'b0, i_wb});
    sum     = 66'(prod_a) + 66'(prod_b);
    shifted = i_avg ? (sum >>> 17) : (sum >>> 16);
    y_nxt   = shifted[31:0];
  end

  // Result register.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      y_r <= 32'h00000000;
    end else begin
      y_r <= y_nxt;
    end
  end

  assign o_y = y_r;

endmodule : pol_weight_unit
`default_nettype wire

// ---- verilog/polar_moment_channel_weighting.sv ----
// Overview of operation
// - Fixed H, co only: HH passes unchanged.
// - Fixed H, cross only: VH times inverse xdr.
// - Fixed H uses horizontal calibration and noise.
// - Fixed H, both: average HH and scaled VH.
// - Fixed V uses vertical calibration; VV unchanged.
// - Fixed V, cross only: HV times xdr.
// - Fixed V, both: average VV and scaled HV.
// - Simultaneous/alternating single, V only: VV over gdr.
// - Both transmits: average HH and VV over gdr.
// - Those modes ignore receive answers.
// - Dual alternating: four answers pick six paths.
// - Dual VH, VV, HH+VV reuse earlier paths.
// - Dual HV only: HV times xdr over gdr.
// - HV+VH: average both differently scaled terms.
`timescale 1ns/10ps
`default_nettype none
module polar_moment_channel_weighting
  import polar_weight_pkg::*;
(
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [7:0]  I_AWADDR,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  output logic      [1:0]  O_BRESP,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  input  wire logic [7:0]  I_ARADDR,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  output logic      [31:0] O_RDATA,
  output logic      [1:0]  O_RRESP,
  input  wire logic        I_TERM_VALID,
  input  wire logic [2:0]  I_TERM_KIND,
  input  wire logic [31:0] I_HH,
  input  wire logic [31:0] I_VH,
  input  wire logic [31:0] I_VV,
  input  wire logic [31:0] I_HV,
  output logic             O_TERM_VALID,
  output logic      [2:0]  O_TERM_KIND,
  output logic      [31:0] O_TERM_DATA,
  output logic             O_USE_V_CAL,
  output logic             O_CFG_ERROR,
  output logic             O_IRQ
);

  typedef enum logic [5:0] {
    F_IDLE = 6'h01,
    F_EXPX = 6'h02,
    F_EXPG = 6'h04,
    F_DIVX = 6'h08,
    F_DIVG = 6'h10,
    F_QUOT = 6'h20
  } fstate_t;

  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, aw_take, w_take, wr_fire, wr_hit;
  logic [1:0]  bresp_r, bresp_nxt;
  logic [7:0]  waddr_r, waddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic arready_r, arready_nxt, rvalid_r, rvalid_nxt, ar_take;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  logic [7:0]  ctrl_r, ctrl_nxt;
  logic [9:0]  xdr_db_r, xdr_db_nxt, gdr_db_r, gdr_db_nxt;
  logic [IRQ_W-1:0] istat_r, istat_nxt, imask_r, imask_nxt, events;
  logic start_r, start_nxt, irq_r, irq_nxt;
  fstate_t fst_r, fst_nxt;
  logic [5:0]  cnt_r, cnt_nxt;
  logic [31:0] acc_r, acc_nxt, lx_r, lx_nxt, lg_r, lg_nxt;
  logic [33:0] rem_r, rem_nxt, rem_sh, div_ext;
  logic [32:0] q_r, q_nxt;
  logic [31:0] xdr_r, xdr_nxt, xinv_r, xinv_nxt, ginv_r, ginv_nxt;
  logic [31:0] quot_r, quot_nxt, step;
  logic        ready_r, ready_nxt, loaded, cur_bit;
  logic [2:0]  mode;
  logic        h_x, v_x, co, cx, ok, avg;
  logic [1:0]  sel_a, sel_b;
  logic [31:0] wa, wb, term_a, term_b;
  logic        tv_r, tv_nxt, vcal_r, vcal_nxt, cerr_r, cerr_nxt;
  logic [2:0]  tk_r, tk_nxt;

  // Unsigned Q16.16 product.
  function automatic logic [31:0] qmul(input logic [31:0] a,
                                       input logic [31:0] b);
    logic [63:0] p;
    p = {32'h00000000, a} * {32'h00000000, b};
    return p[47:16];
  endfunction : qmul

  // Merge write data into a register under the byte enables.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[8*i +: 8] = data[8*i +: 8];
      end
    end
    return m;
  endfunction : merge

  // Selects one of the four correlator lanes.
  function automatic logic [31:0] lane(input logic [1:0] idx);
    case (idx)
      LANE_HH: lane = I_HH;
      LANE_VH: lane = I_VH;
      LANE_VV: lane = I_VV;
      default: lane = I_HV;
    endcase
  endfunction : lane

  // Write channel: address and data are held until both are present.
  always_comb begin
    aw_take     = I_AWVALID & awready_r;
    w_take      = I_WVALID & wready_r;
    wr_fire     = aw_have_r & w_have_r & ~bvalid_r;
    waddr_nxt   = aw_take ? I_AWADDR : waddr_r;
    wdata_nxt   = w_take ? I_WDATA : wdata_r;
    wstrb_nxt   = w_take ? I_WSTRB : wstrb_r;
    aw_have_nxt = wr_fire ? 1'b0 : (aw_have_r | aw_take);
    w_have_nxt  = wr_fire ? 1'b0 : (w_have_r | w_take);
    bvalid_nxt  = wr_fire | (bvalid_r & ~I_BREADY);
    wr_hit      = (waddr_r == OFS_CTRL) || (waddr_r == OFS_XDR_DB) ||
                  (waddr_r == OFS_GDR_DB) || (waddr_r == OFS_IRQ_STAT) ||
                  (waddr_r == OFS_IRQ_MASK);
    bresp_nxt   = wr_fire ? (wr_hit ? RESP_OKAY : RESP_SLVERR) : bresp_r;
    awready_nxt = ~aw_have_nxt & ~bvalid_nxt;
    wready_nxt  = ~w_have_nxt & ~bvalid_nxt;
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      waddr_r   <= 8'h00;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      waddr_r   <= waddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
    end
  end

  // Read channel: one read at a time, data one cycle after the address.
  always_comb begin
    ar_take     = I_ARVALID & arready_r;
    rvalid_nxt  = ar_take | (rvalid_r & ~I_RREADY);
    arready_nxt = ~rvalid_nxt;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (ar_take) begin
      rresp_nxt = RESP_OKAY;
      case (I_ARADDR)
        OFS_CTRL:     rdata_nxt = {24'h000000, ctrl_r};
        OFS_XDR_DB:   rdata_nxt = {22'h000000, xdr_db_r};
        OFS_GDR_DB:   rdata_nxt = {22'h000000, gdr_db_r};
        OFS_STATUS:   rdata_nxt = {28'h0000000, vcal_r, ok, ready_r,
                                   ~fst_r[0]};
        OFS_IRQ_STAT: rdata_nxt = {29'h00000000, istat_r};
        OFS_IRQ_MASK: rdata_nxt = {29'h00000000, imask_r};
        OFS_XDR_LIN:  rdata_nxt = xdr_r;
        OFS_QUOT_LIN: rdata_nxt = quot_r;
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= RESP_OKAY;
    end else begin
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // Setup registers; a write to setup or gains launches a factor load.
  always_comb begin
    logic [31:0] m;
    m          = merge(32'h00000000, wdata_r, wstrb_r);
    ctrl_nxt   = ctrl_r;
    xdr_db_nxt = xdr_db_r;
    gdr_db_nxt = gdr_db_r;
    imask_nxt  = imask_r;
    start_nxt  = 1'b0;
    istat_nxt  = istat_r;
    if (wr_fire) begin
      case (waddr_r)
        OFS_CTRL: begin
          ctrl_nxt  = 8'(merge({24'h000000, ctrl_r}, wdata_r, wstrb_r));
          start_nxt = 1'b1;
        end
        OFS_XDR_DB: begin
          xdr_db_nxt = 10'(merge({22'h000000, xdr_db_r}, wdata_r, wstrb_r));
          start_nxt  = 1'b1;
        end
        OFS_GDR_DB: begin
          gdr_db_nxt = 10'(merge({22'h000000, gdr_db_r}, wdata_r, wstrb_r));
          start_nxt  = 1'b1;
        end
        OFS_IRQ_STAT: istat_nxt = istat_r & ~m[IRQ_W-1:0];
        OFS_IRQ_MASK: imask_nxt = m[IRQ_W-1:0];
        default: ;
      endcase
    end
    istat_nxt = istat_nxt | events; // A new event wins over the clear.
    irq_nxt   = |(istat_nxt & imask_nxt);
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      ctrl_r   <= 8'h00;
      xdr_db_r <= 10'h000;
      gdr_db_r <= 10'h000;
      istat_r  <= '0;
      imask_r  <= '0;
      start_r  <= 1'b0;
      irq_r    <= 1'b0;
    end else begin
      ctrl_r   <= ctrl_nxt;
      xdr_db_r <= xdr_db_nxt;
      gdr_db_r <= gdr_db_nxt;
      istat_r  <= istat_nxt;
      imask_r  <= imask_nxt;
      start_r  <= start_nxt;
      irq_r    <= irq_nxt;
    end
  end

  // Factor engine: 10^(dB/10) by bit products, then reciprocals and xdr/gdr.
  always_comb begin
    fst_nxt   = fst_r;
    cnt_nxt   = cnt_r;
    acc_nxt   = acc_r;
    lx_nxt    = lx_r;
    lg_nxt    = lg_r;
    rem_nxt   = rem_r;
    q_nxt     = q_r;
    xdr_nxt   = xdr_r;
    xinv_nxt  = xinv_r;
    ginv_nxt  = ginv_r;
    quot_nxt  = quot_r;
    ready_nxt = ready_r;
    loaded    = 1'b0;
    step      = DB_STEP_GAIN[cnt_r[3:0]];
    cur_bit   = fst_r[2] ? gdr_db_r[cnt_r[3:0]] : xdr_db_r[cnt_r[3:0]];
    div_ext   = {2'b00, fst_r[3] ? lx_r : lg_r};
    rem_sh    = {rem_r[32:0], (cnt_r == 6'h00)};
    case (fst_r)
      F_IDLE: ;
      F_EXPX, F_EXPG: begin
        if (cur_bit) begin
          acc_nxt = qmul(acc_r, step);
        end
        cnt_nxt = cnt_r + 6'h01;
        if (cnt_r == MAG_LAST) begin
          cnt_nxt = 6'h00;
          acc_nxt = Q_ONE;
          rem_nxt = '0;
          q_nxt   = '0;
          if (fst_r == F_EXPX) begin
            lx_nxt  = cur_bit ? qmul(acc_r, step) : acc_r;
            fst_nxt = F_EXPG;
          end else begin
            lg_nxt  = cur_bit ? qmul(acc_r, step) : acc_r;
            fst_nxt = F_DIVX;
          end
        end
      end
      F_DIVX, F_DIVG: begin
        if (rem_sh >= div_ext) begin
          rem_nxt = rem_sh - div_ext;
          q_nxt   = {q_r[31:0], 1'b1};
        end else begin
          rem_nxt = rem_sh;
          q_nxt   = {q_r[31:0], 1'b0};
        end
        cnt_nxt = cnt_r + 6'h01;
        if (cnt_r == DIV_LAST) begin
          cnt_nxt = 6'h00;
          rem_nxt = '0;
          if (fst_r == F_DIVX) begin
            xdr_nxt  = xdr_db_r[DB_SIGN_BIT] ? q_nxt[31:0] : lx_r;
            xinv_nxt = xdr_db_r[DB_SIGN_BIT] ? lx_r : q_nxt[31:0];
            q_nxt    = '0;
            fst_nxt  = F_DIVG;
          end else begin
            ginv_nxt = gdr_db_r[DB_SIGN_BIT] ? lg_r : q_nxt[31:0];
            fst_nxt  = F_QUOT;
          end
        end
      end
      F_QUOT: begin
        quot_nxt  = qmul(xdr_r, ginv_r);
        ready_nxt = 1'b1;
        loaded    = 1'b1;
        fst_nxt   = F_IDLE;
      end
      default: fst_nxt = F_IDLE;
    endcase
    if (start_r) begin
      fst_nxt   = F_EXPX;
      cnt_nxt   = 6'h00;
      acc_nxt   = Q_ONE;
      ready_nxt = 1'b0;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      fst_r   <= F_IDLE;
      cnt_r   <= 6'h00;
      acc_r   <= Q_ONE;
      lx_r    <= Q_ONE;
      lg_r    <= Q_ONE;
      rem_r   <= '0;
      q_r     <= '0;
      xdr_r   <= Q_ONE;
      xinv_r  <= Q_ONE;
      ginv_r  <= Q_ONE;
      quot_r  <= Q_ONE;
      ready_r <= 1'b1;
    end else begin
      fst_r   <= fst_nxt;
      cnt_r   <= cnt_nxt;
      acc_r   <= acc_nxt;
      lx_r    <= lx_nxt;
      lg_r    <= lg_nxt;
      rem_r   <= rem_nxt;
      q_r     <= q_nxt;
      xdr_r   <= xdr_nxt;
      xinv_r  <= xinv_nxt;
      ginv_r  <= ginv_nxt;
      quot_r  <= quot_nxt;
      ready_r <= ready_nxt;
    end
  end

  // Path selection from polarization case and the four setup answers.
  always_comb begin
    mode  = ctrl_r[CTRL_MODE_LO +: 3];
    h_x   = ctrl_r[CTRL_H_XMT];
    v_x   = ctrl_r[CTRL_V_XMT];
    co    = ctrl_r[CTRL_USE_COPOLAR_RECEIVE_ANSWER];
    cx    = ctrl_r[CTRL_USE_CROSSPOLAR_RECEIVE_ANSWER];
    ok    = 1'b1;
    avg   = 1'b0;
    sel_a = LANE_HH;
    sel_b = LANE_HH;
    wa    = Q_ONE;
    wb    = Q_ZERO;
    case (mode)
      MODE_FIXED_H: begin
        // Every fixed-H path is scaled onto the H co-channel calibration.
        case ({co, cx})
          2'b10: ;
          2'b01: begin
            sel_a = LANE_VH;
            wa    = xinv_r;
          end
          2'b11: begin
            sel_b = LANE_VH;
            wb    = xinv_r;
            avg   = 1'b1;
          end
          default: ok = 1'b0;
        endcase
      end
      MODE_FIXED_V: begin
        case ({co, cx})
          2'b10: sel_a = LANE_VV;
          2'b01: begin
            sel_a = LANE_HV;
            wa    = xdr_r;
          end
          2'b11: begin
            sel_a = LANE_VV;
            sel_b = LANE_HV;
            wb    = xdr_r;
            avg   = 1'b1;
          end
          default: ok = 1'b0;
        endcase
      end
      MODE_SIMUL, MODE_ALT_SNGL: begin
        case ({h_x, v_x})
          2'b10: ;
          2'b01: begin
            sel_a = LANE_VV;
            wa    = ginv_r;
          end
          2'b11: begin
            sel_b = LANE_VV;
            wb    = ginv_r;
            avg   = 1'b1;
          end
          default: ok = 1'b0;
        endcase
      end
      MODE_ALT_DUAL: begin
        case ({h_x, v_x, co, cx})
          4'hA: ;
          4'h9: begin
            sel_a = LANE_VH;
            wa    = xinv_r;
          end
          4'h6: begin
            sel_a = LANE_VV;
            wa    = ginv_r;
          end
          4'h5: begin
            sel_a = LANE_HV;
            wa    = quot_r;
          end
          4'hE: begin
            sel_b = LANE_VV;
            wb    = ginv_r;
            avg   = 1'b1;
          end
          4'hD: begin
            sel_a = LANE_HV;
            wa    = quot_r;
            sel_b = LANE_VH;
            wb    = xinv_r;
            avg   = 1'b1;
          end
          default: ok = 1'b0;
        endcase
      end
      default: ok = 1'b0;
    endcase
    term_a = lane(sel_a);
    term_b = lane(sel_b);
  end

  pol_weight_unit u_weight (
    .i_clk (I_CORE_CLK),
    .i_rst (I_RST),
    .i_a   (term_a),
    .i_b   (term_b),
    .i_wa  (wa),
    .i_wb  (wb),
    .i_avg (avg),
    .o_y   (O_TERM_DATA)
  );

  // Output strobe; terms are dropped while setup is bad or factors reload.
  always_comb begin
    tv_nxt   = I_TERM_VALID & ok & ready_r;
    tk_nxt   = I_TERM_VALID ? I_TERM_KIND : tk_r;
    vcal_nxt = (mode == MODE_FIXED_V);
    cerr_nxt = ~ok;
    events   = '0;
    events[IRQ_LOADED]  = loaded;
    events[IRQ_BAD_CFG] = I_TERM_VALID & ~ok;
    events[IRQ_NOT_RDY] = I_TERM_VALID & ok & ~ready_r;
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      tv_r   <= 1'b0;
      tk_r   <= 3'h0;
      vcal_r <= 1'b0;
      cerr_r <= 1'b0;
    end else begin
      tv_r   <= tv_nxt;
      tk_r   <= tk_nxt;
      vcal_r <= vcal_nxt;
      cerr_r <= cerr_nxt;
    end
  end

  assign O_AWREADY    = awready_r;
  assign O_WREADY     = wready_r;
  assign O_BVALID     = bvalid_r;
  assign O_BRESP      = bresp_r;
  assign O_ARREADY    = arready_r;
  assign O_RVALID     = rvalid_r;
  assign O_RDATA      = rdata_r;
  assign O_RRESP      = rresp_r;
  assign O_TERM_VALID = tv_r;
  assign O_TERM_KIND  = tk_r;
  assign O_USE_V_CAL  = vcal_r;
  assign O_CFG_ERROR  = cerr_r;
  assign O_IRQ        = irq_r;

endmodule : polar_moment_channel_weighting
`default_nettype wire

// ---- tb/pmcw_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module pmcw_sva (
  input wire logic       I_CORE_CLK,
  input wire logic       I_RST,
  input wire logic       I_AWVALID,
  input wire logic       O_AWREADY,
  input wire logic       I_WVALID,
  input wire logic       O_WREADY,
  input wire logic       O_BVALID,
  input wire logic       I_BREADY,
  input wire logic       I_ARVALID,
  input wire logic       O_ARREADY,
  input wire logic       O_RVALID,
  input wire logic       I_TERM_VALID,
  input wire logic [2:0] I_TERM_KIND,
  input wire logic       O_TERM_VALID,
  input wire logic [2:0] O_TERM_KIND,
  input wire logic       O_CFG_ERROR
);
  // Every check runs on the core clock and rests while reset is high.
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RST);
  sequence s_wr_take;
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
  endsequence
  sequence s_rd_take;
    I_ARVALID && O_ARREADY;
  endsequence
  a_term_cause: assert property (
    O_TERM_VALID |-> $past(I_TERM_VALID)) else $error("term without cause");
  a_kind_pass: assert property (
    O_TERM_VALID |-> O_TERM_KIND == $past(I_TERM_KIND))
    else $error("term kind changed");
  a_drop_bad: assert property (
    O_CFG_ERROR |-> !O_TERM_VALID) else $error("term passed under bad setup");
  a_wr_answer: assert property (s_wr_take |-> ##[1:2] O_BVALID)
    else $error("write response late");
  a_rd_answer: assert property (s_rd_take |=> O_RVALID)
    else $error("read data late");
  a_bv_once: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
    else $error("write response repeated");
  a_aw_refuse: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("write taken while response pending");
  a_ar_refuse: assert property (O_RVALID |-> !O_ARREADY)
    else $error("read taken while data pending");
endmodule : pmcw_sva
bind polar_moment_channel_weighting pmcw_sva chk_u (
  .I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_AWVALID(I_AWVALID),
  .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY),
  .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .I_ARVALID(I_ARVALID),
  .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID), .I_TERM_VALID(I_TERM_VALID),
  .I_TERM_KIND(I_TERM_KIND), .O_TERM_VALID(O_TERM_VALID),
  .O_TERM_KIND(O_TERM_KIND), .O_CFG_ERROR(O_CFG_ERROR));
`default_nettype wire

// ---- tb/corr_source.sv ----
`timescale 1ns/10ps
`default_nettype none
module corr_source (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_en,
  output logic             o_valid,
  output logic      [2:0]  o_kind,
  output logic      [31:0] o_hh,
  output logic      [31:0] o_vh,
  output logic      [31:0] o_vv,
  output logic      [31:0] o_hv
);
  logic [31:0] a, b;
  function automatic logic [31:0] sx(input logic [31:0] r);
    return {{12{r[19]}}, r[19:0]};
  endfunction : sx
  // Terms come at a random pace; idle lanes toggle so stale data shows.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {o_valid, o_kind, o_hh, o_vh, o_vv, o_hv} <= '0;
    end else if (i_en && ($urandom % 3 != 0)) begin
      a = sx($urandom);
      b = sx($urandom);
      o_valid <= 1'b1;
      o_kind <= o_kind + 3'h1;
      o_hh <= a;
      o_vv <= b;
      o_hv <= (o_kind == 3'h6) ? a : sx($urandom); // Noise shares lanes.
      o_vh <= (o_kind == 3'h6) ? b : sx($urandom);
    end else begin
      o_valid <= 1'b0;
      {o_hh, o_vh, o_vv, o_hv} <= ~{o_hh, o_vh, o_vv, o_hv};
    end
  end
endmodule : corr_source
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import polar_weight_pkg::*;
;
  localparam longint XL = 64'h27CF8A;
  localparam logic [6:0] TBL [22] = '{7'h02, 7'h0D, 7'h03, 7'h20, 7'h12,
    7'h11, 7'h17, 7'h33, 7'h28, 7'h24, 7'h2F, 7'h39, 7'h36, 7'h3C, 7'h4A,
    7'h49, 7'h46, 7'h45, 7'h4E, 7'h4D, 7'h4F, 7'h5A};
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, en;
  logic        awready, wready, bvalid, arready, rvalid, tv, ov, verr;
  logic        vcal, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, od, hh, vh, vv, hv;
  logic [1:0]  bresp, rresp;
  logic [2:0]  tk, ok_k, cur_m;
  logic [3:0]  cur_c;
  logic [34:0] q [$];
  int          n_fail, checks, cyc;
  polar_moment_channel_weighting dut_u (
    .I_CORE_CLK(clk), .I_RST(rst), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_AWADDR(awaddr), .I_WVALID(wvalid), .O_WREADY(wready),
    .I_WDATA(wdata), .I_WSTRB(4'hF), .O_BVALID(bvalid), .I_BREADY(bready),
    .O_BRESP(bresp), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .I_ARADDR(araddr), .O_RVALID(rvalid), .I_RREADY(rready),
    .O_RDATA(rdata), .O_RRESP(rresp), .I_TERM_VALID(tv), .I_TERM_KIND(tk),
    .I_HH(hh), .I_VH(vh), .I_VV(vv), .I_HV(hv), .O_TERM_VALID(ov),
    .O_TERM_KIND(ok_k), .O_TERM_DATA(od), .O_USE_V_CAL(vcal),
    .O_CFG_ERROR(verr), .O_IRQ(irq));
  corr_source src_u (.i_clk(clk), .i_rst(rst), .i_en(en), .o_valid(tv),
    .o_kind(tk), .o_hh(hh), .o_vh(vh), .o_vv(vv), .o_hv(hv));
  // Reference weighting; returns zero for an unsupported setup.
  function automatic bit calc(input logic [2:0] m, input logic [3:0] c,
    input longint h_h, v_h, v_v, h_v, output longint y);
    longint ix, a, wa, b, wb;
    bit avg, ok;
    ix = (64'd1 << 32) / XL;
    {a, b, wb, avg, ok} = '0;
    wa = 65536;
    case (m)
      MODE_FIXED_H, MODE_FIXED_V: begin
        ok = c[1] | c[0];
        avg = c[1] & c[0];
        if (c[1]) a = (m == MODE_FIXED_H) ? h_h : v_v;
        if (c[0]) b = (m == MODE_FIXED_H) ? v_h : h_v;
        if (c[0]) wb = (m == MODE_FIXED_H) ? ix : XL;
      end
      MODE_SIMUL, MODE_ALT_SNGL: begin
        ok = c[3] | c[2];
        avg = c[3] & c[2];
        if (c[3]) a = h_h;
        if (c[2]) {b, wb} = {v_v, 64'd65536};
      end
      MODE_ALT_DUAL: begin
        ok = c inside {4'hA, 4'h9, 4'h6, 4'h5, 4'hE, 4'hD};
        avg = c inside {4'hE, 4'hD};
        if (c[3] && c[1]) a = h_h;
        if (c[2] && c[1]) {b, wb} = {v_v, 64'd65536};
        if (c[3] && c[0]) {b, wb} = {v_h, ix};
        if (c[2] && c[0]) {a, wa} = {h_v, XL};
      end
      default: ok = 0;
    endcase
    y = (a * wa + b * wb) >>> (avg ? 17 : 16);
    return ok;
  endfunction : calc
  task automatic chk(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic stop_test;
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  // Bus write: both channels offered together, each dropped when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_ok, w_ok;
    {aw_ok, w_ok} = 2'b00;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (awready && !aw_ok) awvalid <= 1'b0;
      if (wready && !w_ok) wvalid <= 1'b0;
      aw_ok |= awready;
      w_ok |= wready;
    end
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    chk("bresp", RESP_OKAY, bresp);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    arvalid <= 1'b1;
    araddr <= a;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic wait_irq;
    int t;
    for (t = 0; t < 400 && !irq; t++) @(posedge clk);
    chk("irq raised", 1, irq);
    wr(OFS_IRQ_STAT, 32'h7);
    repeat (2) @(posedge clk);
    chk("irq cleared", 0, irq);
  endtask : wait_irq
  // One setup: load it, stream terms, then look at flags and leftovers.
  task automatic run(input logic [2:0] m, input logic [3:0] c);
    longint y;
    bit ok;
    logic [31:0] d;
    logic [1:0] r;
    ok = calc(m, c, 0, 0, 0, 0, y);
    cur_m = m;
    cur_c = c;
    wr(OFS_CTRL, {24'h0, c[0], c[1], c[2], c[3], 1'b0, m});
    wait_irq();
    rd(OFS_STATUS, d, r);
    chk("status", {28'h0, m == MODE_FIXED_V, ok, 2'b10}, d);
    en <= 1'b1;
    repeat (40) @(posedge clk);
    en <= 1'b0;
    repeat (4) @(posedge clk);
    chk("pending terms", 0, 32'(q.size()));
    chk("cfg error", {31'h0, !ok}, {31'h0, verr});
    chk("v cal", {31'h0, m == MODE_FIXED_V}, {31'h0, vcal});
    rd(OFS_IRQ_STAT, d, r);
    chk("drop flag", {30'h0, !ok, 1'b0}, d & 32'h6);
  endtask : run
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Scoreboard and watchdog: every input term of a supported setup is predicted, outputs popped.
  always @(posedge clk) begin : sb
    longint y;
    logic [34:0] e;
    cyc++;
    if (cyc == 12000) begin
      n_fail++;
      stop_test();
    end
    if (tv && calc(cur_m, cur_c, $signed(hh), $signed(vh), $signed(vv),
        $signed(hv), y)) q.push_back({tk, y[31:0]});
    if (ov && q.size() == 0) chk("extra term", 0, 1);
    if (ov && q.size() != 0) begin
      e = q.pop_front();
      chk("term", e[31:0], od);
      chk("kind", {29'h0, e[34:32]}, {29'h0, ok_k});
    end
  end
  initial begin : main
    logic [31:0] d;
    logic [1:0] r;
    {rst, awvalid, wvalid, bready, arvalid, rready, en} <= 7'h40;
    {awaddr, araddr, wdata, cur_m, cur_c} <= '0;
    void'($urandom(32'h55c37571));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wr(OFS_IRQ_MASK, 32'h1);
    wr(OFS_XDR_DB, 32'h100);
    wr(OFS_GDR_DB, 32'h0);
    wait_irq();
    rd(OFS_XDR_LIN, d, r);
    chk("xdr linear", 32'h0027CF8A, d);
    rd(OFS_QUOT_LIN, d, r);
    chk("xdr over gdr", 32'h0027CF8A, d);
    rd(8'h20, d, r);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    for (int i = 0; i < 22; i++) run(TBL[i][6:4], TBL[i][3:0]);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
